/* File: eeprom_host_pkg.sv */
// constants for the parallel eeprom host controller
// assumes a 250 MHz sys_clk; pin timing is counted in sys_clk cycles
package eeprom_host_pkg;
  localparam int addr_width = 13;
  localparam int data_width = 8;
  localparam int page_bytes = 64;
  localparam int page_lsb = 6;
  localparam int clk_period_ns = 4;
  // strobe phase lengths, each at least one cycle
  localparam int setup_ns = 20;
  localparam int strobe_ns = 100;
  localparam int hold_ns = 20;
  localparam int setup_cycles = (setup_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int strobe_cycles =
    (strobe_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int hold_cycles = (hold_ns + clk_period_ns - 1) / clk_period_ns;
  // byte load limit is a longest time: round down, keep a safety margin
  localparam int byte_load_us = 100;
  localparam int byte_load_margin_us = 10;
  localparam int byte_load_cycles =
    ((byte_load_us - byte_load_margin_us) * 1000) / clk_period_ns;
  // the host gives up polling after poll_limit_cycles relaunched reads of 37 cycles each
  localparam int poll_limit_ms = 10;
  localparam int poll_limit_cycles = (poll_limit_ms * 1000000) / clk_period_ns;
  localparam logic [7:0] data_reset = 8'h00;
  localparam logic [12:0] addr_reset = 13'h0000;
  typedef enum logic [1:0] {
    cmd_read,
    cmd_write,
    cmd_poll_data,
    cmd_poll_toggle
  } cmd_type;
endpackage

/* File: pin_cycle_if.sv */
// strobe request/answer bundle between the sequencer and the pin driver
// both sides run on sys_clk
`timescale 1ns/1ns
interface pin_cycle_if;
  import eeprom_host_pkg::*;
  logic start;
  logic is_write;
  logic [addr_width-1:0] addr;
  logic [data_width-1:0] wdata;
  logic done;
  logic [data_width-1:0] rdata;
  logic we_fall;
  modport master (output start, output is_write, output addr, output wdata,
                  input done, input rdata, input we_fall);
  modport slave (input start, input is_write, input addr, input wdata,
                 output done, output rdata, output we_fall);
endinterface

/* File: pin_cycle.sv */
// drives one read or write strobe cycle on the memory pins
// data_in comes from a pin and is synchronised here
`timescale 1ns/1ns
module pin_cycle
  import eeprom_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // sequencer side
  pin_cycle_if.slave cyc,
  // memory pins
  output logic [addr_width-1:0] byte_address,
  output logic chip_sel_b,
  output logic out_en_b,
  output logic wr_en_b,
  input wire logic [data_width-1:0] data_bus_in,
  output logic [data_width-1:0] data_bus_out,
  output logic data_bus_oe
);
  typedef enum logic [1:0] {ph_idle, ph_setup, ph_strobe, ph_hold} ph_type;
  ph_type ph, next_ph;
  logic [7:0] cnt, next_cnt;
  logic wr, next_wr;
  logic [addr_width-1:0] next_addr;
  logic [data_width-1:0] next_dout;
  logic [data_width-1:0] s1, s2, s3, rd, next_rd;
  logic [data_width-1:0] cap, next_cap;
  logic cs, next_cs, oe, next_oe, we, next_we, drv, next_drv;

  always_comb
  begin
    next_ph = ph;
    next_cnt = cnt;
    next_wr = wr;
    next_addr = byte_address;
    next_dout = data_bus_out;
    next_cs = cs;
    next_oe = oe;
    next_we = we;
    next_drv = drv;
    next_rd = rd;
    next_cap = cap;
    // accept a new data value only when two late stages agree
    if (s2 == s3)
      next_rd = s3;
    case (ph)
      ph_idle:
        if (cyc.start)
        begin
          next_ph = ph_setup;
          next_cnt = 8'(setup_cycles);
          next_wr = cyc.is_write;
          next_addr = cyc.addr;
          next_dout = cyc.wdata;
          next_drv = cyc.is_write;
        end
      ph_setup:
        if (cnt <= 8'h01)
        begin
          next_ph = ph_strobe;
          next_cnt = 8'(strobe_cycles);
          next_cs = 1'b1;
          next_oe = !wr;
          next_we = wr;
        end
        else
          next_cnt = cnt - 8'h01;
      ph_strobe:
        if (cnt <= 8'h01)
        begin
          next_ph = ph_hold;
          next_cnt = 8'(hold_cycles);
          // the device floats the bus once a strobe rises: take the byte now
          next_cap = rd;
          // release both together; data stays driven through hold
          next_cs = 1'b0;
          next_oe = 1'b0;
          next_we = 1'b0;
        end
        else
          next_cnt = cnt - 8'h01;
      ph_hold:
        if (cnt <= 8'h01)
        begin
          next_ph = ph_idle;
          next_drv = 1'b0;
        end
        else
          next_cnt = cnt - 8'h01;
      default:
        next_ph = ph_idle;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ph <= ph_idle;
      cnt <= 8'h00;
      wr <= 1'b0;
      byte_address <= addr_reset;
      data_bus_out <= data_reset;
      cs <= 1'b0;
      oe <= 1'b0;
      we <= 1'b0;
      drv <= 1'b0;
      s1 <= data_reset;
      s2 <= data_reset;
      s3 <= data_reset;
      rd <= data_reset;
      cap <= data_reset;
    end
    else
    begin
      ph <= next_ph;
      cnt <= next_cnt;
      wr <= next_wr;
      byte_address <= next_addr;
      data_bus_out <= next_dout;
      cs <= next_cs;
      oe <= next_oe;
      we <= next_we;
      drv <= next_drv;
      s1 <= data_bus_in;
      s2 <= s1;
      s3 <= s2;
      rd <= next_rd;
      cap <= next_cap;
    end
  end

  assign chip_sel_b = !cs;
  assign out_en_b = !oe;
  assign wr_en_b = !we;
  assign data_bus_oe = drv;
  // read data was taken at the end of the strobe, while the device drove it
  assign cyc.done = (ph == ph_hold) && (cnt <= 8'h01);
  assign cyc.rdata = cap;
  assign cyc.we_fall = (ph == ph_setup) && (cnt <= 8'h01) && wr;
endmodule

/* File: eeprom_host.sv */
// host controller for a byte-wide self-timed eeprom with page writes
// user side issues read, write-byte and poll requests; one clock domain
//
// How it works
// - reads assert chip select and output enable together, write enable high.
// - writes assert chip select and write enable with output enable high.
// - a byte outside the open page waits for it to close and for programming.
// - next write strobe falls well inside the byte-load limit.
// - chip select is high whenever no cycle runs.
// - other bus activity between loads is allowed within the limit.
`timescale 1ns/1ns
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int load_limit = byte_load_cycles,
  parameter int poll_limit = poll_limit_cycles
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // user request
  input wire logic req_valid,
  input wire cmd_type req_cmd,
  input wire logic [addr_width-1:0] req_addr,
  input wire logic [data_width-1:0] req_wdata,
  output logic req_ready,
  // user answer
  output logic resp_valid,
  output logic [data_width-1:0] resp_rdata,
  output logic resp_timeout,
  output logic page_open,
  // memory pins
  output logic [addr_width-1:0] byte_address,
  output logic chip_sel_b,
  output logic out_en_b,
  output logic wr_en_b,
  input wire logic [data_width-1:0] data_bus_in,
  output logic [data_width-1:0] data_bus_out,
  output logic data_bus_oe
);
  typedef enum logic [2:0] {
    st_idle, st_cycle, st_close, st_poll, st_poll_wait
  } st_type;
  st_type st, next_st;
  cmd_type cmd, next_cmd;
  logic [addr_width-1:0] addr, next_addr;
  logic [data_width-1:0] wdata, next_wdata;
  logic [data_width-1:0] last_data, next_last_data;
  logic [addr_width-1:0] last_addr, next_last_addr;
  logic [addr_width-1:page_lsb] page, next_page;
  logic [6:0] loaded, next_loaded;
  logic open, next_open;
  logic [31:0] load_cnt, next_load_cnt;
  logic [31:0] poll_cnt, next_poll_cnt;
  logic prev6, next_prev6, have6, next_have6;
  logic busy, next_busy;
  logic rv, next_rv, to, next_to;
  logic [data_width-1:0] rdat, next_rdat;
  logic start;
  logic same_page;
  logic expire;

  pin_cycle_if cyc ();

  pin_cycle u_pin
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .cyc(cyc),
    .byte_address(byte_address),
    .chip_sel_b(chip_sel_b),
    .out_en_b(out_en_b),
    .wr_en_b(wr_en_b),
    .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe)
  );

  assign same_page = open && (req_addr[addr_width-1:page_lsb] == page);
  assign expire = open && !cyc.we_fall && (load_cnt == 32'h0);
  // a write outside the open page waits for it to close, then for a poll;
  // reads pass freely between page loads
  assign req_ready = (st == st_idle) && !(req_cmd == cmd_write &&
    (expire || ((busy || open) && !same_page)));
  assign start = (st == st_idle && req_valid && req_ready) ||
    (st == st_poll);
  assign cyc.start = start;
  assign cyc.is_write = (st == st_idle) && (req_cmd == cmd_write);
  // data polling must read the last written location, whatever was asked
  assign cyc.addr = (st == st_poll || req_cmd == cmd_poll_data) ?
    last_addr : req_addr;
  assign cyc.wdata = req_wdata;
  assign resp_valid = rv;
  assign resp_rdata = rdat;
  assign resp_timeout = to;
  assign page_open = open;

  always_comb
  begin
    next_st = st;
    next_cmd = cmd;
    next_addr = addr;
    next_wdata = wdata;
    next_last_data = last_data;
    next_last_addr = last_addr;
    next_page = page;
    next_loaded = loaded;
    next_open = open;
    next_load_cnt = load_cnt;
    next_poll_cnt = poll_cnt;
    next_prev6 = prev6;
    next_have6 = have6;
    next_busy = busy;
    next_rv = 1'b0;
    next_to = 1'b0;
    next_rdat = rdat;
    // byte-load timer runs from each write strobe fall
    if (open)
    begin
      if (cyc.we_fall)
        next_load_cnt = 32'(load_limit);
      else if (load_cnt != 32'h0)
        next_load_cnt = load_cnt - 32'h1;
      else
        next_open = 1'b0;
    end
    case (st)
      st_idle:
        if (req_valid && req_ready)
        begin
          next_cmd = req_cmd;
          next_addr = req_addr;
          next_wdata = req_wdata;
          if (req_cmd == cmd_write)
          begin
            // writes to a new page start a fresh load
            if (!same_page)
            begin
              next_page = req_addr[addr_width-1:page_lsb];
              next_loaded = 7'h00;
            end
            next_open = 1'b1;
            next_load_cnt = 32'(load_limit);
            next_last_addr = req_addr;
            next_last_data = req_wdata;
          end
          if (req_cmd == cmd_poll_data || req_cmd == cmd_poll_toggle)
          begin
            next_poll_cnt = 32'(poll_limit);
            next_have6 = 1'b0;
          end
          next_st = st_cycle;
        end
      st_cycle:
        if (cyc.done)
        begin
          next_rdat = cyc.rdata;
          if (cmd == cmd_write)
          begin
            next_loaded = loaded + 7'h01;
            // a full page closes now, without waiting for the byte-load timer
            if (loaded + 7'h01 >= 7'(page_bytes))
              next_st = st_close;
            else
            begin
              next_st = st_idle;
              next_rv = 1'b1;
            end
          end
          else if (cmd == cmd_read)
          begin
            next_st = st_idle;
            next_rv = 1'b1;
          end
          else
            next_st = st_poll_wait;
        end
      st_close:
      begin
        // no more bytes fit; close the page at once, mark busy and answer
        next_open = 1'b0;
        next_busy = 1'b1;
        next_st = st_idle;
        next_rv = 1'b1;
      end
      st_poll_wait:
      begin
        next_st = st_poll;
        if (cmd == cmd_poll_data)
        begin
          if (rdat[7] == last_data[7])
          begin
            next_busy = 1'b0;
            next_st = st_idle;
            next_rv = 1'b1;
          end
        end
        else if (have6 && rdat[6] == prev6)
        begin
          next_busy = 1'b0;
          next_st = st_idle;
          next_rv = 1'b1;
        end
        next_prev6 = rdat[6];
        next_have6 = 1'b1;
        if (next_st == st_poll && poll_cnt == 32'h0)
        begin
          next_st = st_idle;
          next_rv = 1'b1;
          next_to = 1'b1;
        end
      end
      st_poll:
      begin
        // relaunch a read of the last written location
        next_st = st_cycle;
        if (poll_cnt != 32'h0)
          next_poll_cnt = poll_cnt - 32'h1;
      end
      default:
        next_st = st_idle;
    endcase
    // a poll ending in the cycle the page closes must not clear busy
    if (expire)
      next_busy = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      st <= st_idle;
      cmd <= cmd_read;
      addr <= addr_reset;
      wdata <= data_reset;
      last_data <= data_reset;
      last_addr <= addr_reset;
      page <= '0;
      loaded <= 7'h00;
      open <= 1'b0;
      load_cnt <= 32'h0;
      poll_cnt <= 32'h0;
      prev6 <= 1'b0;
      have6 <= 1'b0;
      busy <= 1'b0;
      rv <= 1'b0;
      to <= 1'b0;
      rdat <= data_reset;
    end
    else
    begin
      st <= next_st;
      cmd <= next_cmd;
      addr <= next_addr;
      wdata <= next_wdata;
      last_data <= next_last_data;
      last_addr <= next_last_addr;
      page <= next_page;
      loaded <= next_loaded;
      open <= next_open;
      load_cnt <= next_load_cnt;
      poll_cnt <= next_poll_cnt;
      prev6 <= next_prev6;
      have6 <= next_have6;
      busy <= next_busy;
      rv <= next_rv;
      to <= next_to;
      rdat <= next_rdat;
    end
  end
endmodule

/* File: eeprom_model.sv */
// behavioural byte-wide self-timed eeprom with page load and status bits
// driven by the host pins; the bench resolves the shared data bus
`timescale 1ns/1ns
module eeprom_model
#(
  parameter int window_ns = 180,
  parameter int fast_ns = 1000,
  parameter int slow_ns = 6000
)
(
  // memory pins
  input wire logic [12:0] byte_address,
  input wire logic chip_sel_b,
  input wire logic out_en_b,
  input wire logic wr_en_b,
  input wire logic [7:0] data_bus,
  output logic [7:0] q = 8'h00,
  // programming speed
  input wire logic slow
);
  logic [7:0] mem [8192] = '{default: 8'h00};
  logic [7:0] pg [64];
  logic [63:0] ld = '0;
  logic [12:0] la = 13'h0000;
  logic [6:0] pa = 7'h00;
  logic loading = 1'b0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  time t_we = 0;
  time t_end = 0;
  wire wsel = !chip_sel_b && !wr_en_b && out_en_b;
  wire rsel = !chip_sel_b && !out_en_b;
  always @(posedge wsel)
    if (!busy)
    begin
      la = byte_address;
      if (!loading)
        pa = byte_address[12:6];
      loading = 1'b1;
      t_we = $time;
    end
  always @(negedge wsel)
    if (!busy && loading)
    begin
      pg[la[5:0]] = data_bus;
      ld[la[5:0]] = 1'b1;
    end
  // polled in small steps; close timing is good to 4 ns only
  always #4
  begin
    if (loading && !wsel && $time - t_we >= window_ns)
    begin
      for (int i = 0; i < 64; i++)
        if (ld[i])
          mem[{pa, i[5:0]}] = pg[i];
      ld = '0;
      loading = 1'b0;
      busy = 1'b1;
      t_end = $time + (slow ? slow_ns : fast_ns);
    end
    if (busy && $time >= t_end)
      busy = 1'b0;
  end
  always @(posedge rsel)
  begin
    q = mem[byte_address];
    if (busy)
    begin
      q[7] = (byte_address == la) ? ~pg[la[5:0]][7] : 1'b0;
      q[6] = tog;
      tog = ~tog;
    end
  end
  // released bus shows the inverse so a stale value never passes
  always @(negedge rsel)
    q = ~q;
endmodule

/* File: eeprom_host_monitor.sv */
// assertions on the eeprom host pins and user handshake
// bound into eeprom_host; sees only its ports
`timescale 1ns/1ns
module eeprom_host_monitor
  import eeprom_host_pkg::*;
#(
  parameter int load_limit = 50
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // user side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic resp_timeout,
  input wire logic page_open,
  // memory pins
  input wire logic [addr_width-1:0] byte_address,
  input wire logic chip_sel_b,
  input wire logic out_en_b,
  input wire logic wr_en_b,
  input wire logic [data_width-1:0] data_bus_out,
  input wire logic data_bus_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  int cnt;
  // cycles since the write strobe last fell, saturating
  always_ff @(posedge sys_clk)
    if (!rst_b || $fell(wr_en_b))
      cnt <= 0;
    else if (cnt < 100000)
      cnt <= cnt + 1;
  sequence s_low;
    !chip_sel_b [*8];
  endsequence
  property p_wr_form;
    !wr_en_b |-> out_en_b && data_bus_oe && !chip_sel_b;
  endproperty
  a_wr_form: assert property (p_wr_form)
    else $error("write strobe form wrong");
  property p_rd_form;
    !out_en_b |-> wr_en_b && !data_bus_oe && !chip_sel_b;
  endproperty
  a_rd_form: assert property (p_rd_form)
    else $error("read strobe form wrong");
  property p_idle;
    req_ready |-> chip_sel_b;
  endproperty
  a_idle: assert property (p_idle)
    else $error("chip select low while idle");
  property p_setup;
    $fell(chip_sel_b) |-> byte_address == $past(byte_address, 5);
  endproperty
  a_setup: assert property (p_setup)
    else $error("address setup short");
  property p_addr_hold;
    !chip_sel_b && $past(!chip_sel_b) |-> $stable(byte_address);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved in strobe");
  property p_data_hold;
    $rose(wr_en_b) |-> data_bus_oe && $stable(data_bus_out);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data not held");
  property p_strobe;
    $fell(chip_sel_b) |-> s_low ##[17:19] $rose(chip_sel_b);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe length wrong");
  property p_taken;
    req_valid && req_ready |=> !req_ready;
  endproperty
  a_taken: assert property (p_taken)
    else $error("request taken twice");
  property p_timeout;
    resp_timeout |-> resp_valid;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout without answer");
  property p_window;
    $fell(page_open) |-> cnt <= load_limit + 40;
  endproperty
  a_window: assert property (p_window)
    else $error("page held open too long");
endmodule
bind eeprom_host eeprom_host_monitor #(.load_limit(load_limit)) u_mon (
  .sys_clk, .rst_b, .req_valid, .req_ready, .resp_valid, .resp_timeout,
  .page_open, .byte_address, .chip_sel_b, .out_en_b, .wr_en_b,
  .data_bus_out, .data_bus_oe
);

/* File: test_eeprom_host.sv */
// self-checking bench for eeprom_host against a behavioural memory
// assumes eeprom_model and the bound monitor are compiled before it
`timescale 1ns/1ns
module test_eeprom_host;
  import eeprom_host_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  cmd_type req_cmd = cmd_read;
  logic [12:0] req_addr = 13'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic slow = 1'b0;
  logic req_ready, resp_valid, resp_timeout, page_open, to;
  logic chip_sel_b, out_en_b, wr_en_b, data_bus_oe;
  logic [7:0] resp_rdata, data_bus_out, q, rd, r1, d;
  logic [12:0] byte_address, a;
  logic [7:0] exp [64];
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 3;
  wire [7:0] bus = data_bus_oe ? data_bus_out : q;
  always #2 sys_clk = ~sys_clk;
  eeprom_host #(.load_limit(50), .poll_limit(20)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .resp_timeout(resp_timeout),
    .page_open(page_open), .byte_address(byte_address),
    .chip_sel_b(chip_sel_b), .out_en_b(out_en_b), .wr_en_b(wr_en_b),
    .data_bus_in(bus), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe));
  eeprom_model M (.byte_address(byte_address), .chip_sel_b(chip_sel_b),
    .out_en_b(out_en_b), .wr_en_b(wr_en_b), .data_bus(bus), .q(q),
    .slow(slow));
  task test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task req(input cmd_type c, input logic [12:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= ad;
    req_wdata <= dt;
    do @(negedge sys_clk); while (req_ready !== 1'b1);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (resp_valid !== 1'b1 && n < 5000);
    rd = resp_rdata;
    to = resp_timeout;
    if (n >= 5000)
      fails++;
  endtask
  // a write that must be turned away: ready stays low, nothing starts
  task refused(input logic [12:0] ad);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_cmd <= cmd_write;
    req_addr <= ad;
    @(negedge sys_clk);
    chk({7'h0, req_ready}, 8'h00);
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      test_done;
    end
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk({3'h0, chip_sel_b, out_en_b, wr_en_b, data_bus_oe, req_ready},
        8'h1d);
    // a full page loaded back to back, upper bits held
    a = 13'($random(seed)) & 13'h1fc0;
    for (int i = 0; i < 64; i++)
    begin
      exp[i] = 8'($random(seed));
      req(cmd_write, a | 13'(i), exp[i]);
    end
    chk({7'h0, page_open}, 8'h00);
    repeat (60) @(posedge sys_clk);
    req(cmd_poll_data, a | 13'h003f, 8'h00);
    chk({7'h0, to}, 8'h00);
    for (int i = 0; i < 64; i++)
    begin
      req(cmd_read, a | 13'(i), 8'h00);
      chk(rd, exp[i]);
    end
    // status lines seen while programming runs
    a = 13'($random(seed));
    d = 8'($random(seed));
    req(cmd_write, a, d);
    repeat (130) @(posedge sys_clk);
    req(cmd_read, a, 8'h00);
    r1 = rd;
    chk({7'h0, rd[7]}, {7'h0, ~d[7]});
    req(cmd_read, a ^ 13'h0001, 8'h00);
    chk({7'h0, rd[6]}, {7'h0, ~r1[6]});
    req(cmd_poll_toggle, a, 8'h00);
    chk({7'h0, to}, 8'h00);
    req(cmd_read, a, 8'h00);
    chk(rd, d);
    // reloading one offset keeps the last byte
    d = 8'($random(seed));
    req(cmd_write, a, ~d);
    req(cmd_write, a, d);
    refused(a ^ 13'h0040);
    repeat (60) @(posedge sys_clk);
    req(cmd_poll_toggle, a, 8'h00);
    req(cmd_read, a, 8'h00);
    chk(rd, d);
    // slow programming: polling gives up, other pages refused meanwhile
    slow <= 1'b1;
    req(cmd_write, a, ~d);
    repeat (60) @(posedge sys_clk);
    req(cmd_poll_data, a, 8'h00);
    chk({7'h0, to}, 8'h01);
    refused(a ^ 13'h1000);
    repeat (1000) @(posedge sys_clk);
    req(cmd_poll_data, a, 8'h00);
    chk({7'h0, to}, 8'h00);
    chk(rd, ~d);
    slow <= 1'b0;
    test_done;
  end
endmodule
